// >>> clm_map.svh
`ifndef CLM_MAP_SVH
`define CLM_MAP_SVH

// Function field bit positions, LSB numbering
`define CLM_BIT_EXT 10
`define CLM_BIT_WIDE 7
`define CLM_BIT_FLUSH 4
`define CLM_BIT_MATCH 1
// Exception cause and option values, narrow address width
`define CLM_CAUSE_PRIV 5'h07
`define CLM_CAUSE_RESET 5'h00
`define CLM_ICONN_COHERENT 3
`define CLM_MMU_VIRTUAL 3
`define CLM_NARROW_ADDR 32
// Byte offset bits of a word, bytes per word
`define CLM_WORD_SHIFT 2
`define CLM_WORD_BYTES 4
// Latencies in cycles
`define CLM_LAT_CLEAR 2
`define CLM_LAT_PLAIN_SLOW 3
`define CLM_LAT_IC 2
`endif

// >>> clm_pkg.sv
package clm_pkg;
    // Issued maintenance operation
    typedef struct packed {
        logic is_ic;
        logic [10:0] func;
        logic [31:0] ra;
        logic [31:0] rb;
        logic [31:0] ra_phys;
    } clm_op_t;
    // Controller states
    typedef enum logic [2:0] {S_IDLE, S_LOOK, S_EXTRA, S_WB, S_EXT} clm_state_t;
endpackage

// >>> clm_line_index.sv
`timescale 1ns/100ps
`default_nettype none
`include "clm_map.svh"
module clm_line_index #(
    parameter int ADDR_W = 32,
    parameter int WORDS = 4,
    parameter int LINES = 64
) (
    // Address in
    input wire logic [ADDR_W-1:0] addr,
    // Line index and aligned line address
    output logic [$clog2(LINES)-1:0] idx,
    output logic [ADDR_W-1:0] line_addr
);
    localparam int SH = $clog2(WORDS) + `CLM_WORD_SHIFT;
    localparam int IW = $clog2(LINES);
    localparam logic [ADDR_W-1:0] LMASK = ~(ADDR_W'(WORDS * `CLM_WORD_BYTES - 1));

    if (!(WORDS == 4 || WORDS == 8 || WORDS == 16) || (1 << IW) != LINES || SH + IW > ADDR_W)
    begin : g_bad
        $error("clm_line_index: unsupported line geometry");
    end

    // Shift by 4, 5 or 6 and mask to depth; align line address
    assign idx = addr[SH +: IW];
    assign line_addr = addr & LMASK;
endmodule
`default_nettype wire

// >>> clm_maint.sv
`timescale 1ns/100ps
`default_nettype none
`include "clm_map.svh"
module clm_maint #(
    parameter int ADDR_W = 32,
    parameter int DC_LINES = 64,
    parameter int DC_WORDS = 4,
    parameter int IC_LINES = 64,
    parameter int IC_WORDS = 4,
    parameter int DATA_CACHE_POLICY_OPTION = 1,
    parameter int TRANSLATION_UNIT_OPTION = 0,
    parameter int INTERCONNECT_OPTION = 2,
    parameter int AREA_OPTION = 0
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Issue stage
    input wire logic op_valid,
    output logic op_ready,
    input wire clm_pkg::clm_op_t op,
    input wire logic user_privilege_flag,
    input wire logic translation_active,
    output logic done,
    output logic exc_valid,
    output logic [4:0] exception_cause_field,
    // Data cache line fill
    input wire logic fill_valid,
    output logic fill_ready,
    input wire logic [$clog2(DC_LINES)-1:0] fill_line,
    input wire logic [$clog2(DC_WORDS)-1:0] fill_word,
    input wire logic [ADDR_W-1:0] fill_tag,
    input wire logic [31:0] fill_data,
    input wire logic fill_dirty,
    // Instruction cache line fill
    input wire logic ic_fill_valid,
    input wire logic [$clog2(IC_LINES)-1:0] ic_fill_line,
    // Memory write-back
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [31:0] mem_wr_data,
    // External cache request
    output logic ext_req_valid,
    input wire logic ext_req_ready,
    output logic ext_req_flush,
    output logic [ADDR_W-1:0] ext_req_addr,
    // Line state view
    output logic [DC_LINES-1:0] dc_line_valid,
    output logic [IC_LINES-1:0] ic_line_valid
);
    localparam int DIW = $clog2(DC_LINES);
    localparam int IIW = $clog2(IC_LINES);
    localparam int WW = $clog2(DC_WORDS);

    if (ADDR_W < `CLM_NARROW_ADDR || ADDR_W > 64) begin : g_bad
        $error("clm_maint: address width must be 32 to 64");
    end

    // ----------------------------------------------------------------
    // Decode and address forming
    // ----------------------------------------------------------------
    function automatic logic fbit(input logic [10:0] f, input int pos);
        fbit = f[pos];
    endfunction

    clm_pkg::clm_state_t state_q;
    clm_pkg::clm_op_t op_q;
    logic priv_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [63:0] wide_addr;
    logic [63:0] sum_addr;
    logic [63:0] ic_addr;
    logic accept;
    logic q_ext;
    logic q_flush;
    logic q_match;
    logic [WW-1:0] wcnt_q;

    // Variant bits of the function field
    assign q_ext = fbit(op_q.func, `CLM_BIT_EXT) && DATA_CACHE_POLICY_OPTION == 0
        && INTERCONNECT_OPTION == `CLM_ICONN_COHERENT;
    assign q_flush = fbit(op_q.func, `CLM_BIT_FLUSH);
    assign q_match = fbit(op_q.func, `CLM_BIT_MATCH);

    assign accept = op_valid && op_ready && ce;
    assign wide_addr = {op.ra, op.rb};
    assign sum_addr = {32'h0000_0000, op.ra + op.rb};
    // Instruction side uses virtual address only under full translation
    assign ic_addr = {32'h0000_0000, (TRANSLATION_UNIT_OPTION == `CLM_MMU_VIRTUAL && translation_active)
        ? op.ra : op.ra_phys};

    // Line address from operands; data side is always physical
    always_comb
    begin
        addr_d = sum_addr[ADDR_W-1:0];
        if (op.is_ic)
        begin
            addr_d = ic_addr[ADDR_W-1:0];
        end
        else if (DATA_CACHE_POLICY_OPTION == 1)
        begin
            if (fbit(op.func, `CLM_BIT_MATCH) && fbit(op.func, `CLM_BIT_WIDE)
                && ADDR_W > `CLM_NARROW_ADDR)
            begin
                addr_d = wide_addr[ADDR_W-1:0];
            end
        end
        else if (!(fbit(op.func, `CLM_BIT_EXT) && INTERCONNECT_OPTION == `CLM_ICONN_COHERENT))
        begin
            addr_d = ADDR_W'(op.ra);
        end
    end

    // ----------------------------------------------------------------
    // Line indexing
    // ----------------------------------------------------------------
    logic [DIW-1:0] dc_idx;
    logic [ADDR_W-1:0] dc_laddr;
    logic [IIW-1:0] ic_idx;

    clm_line_index #(.ADDR_W(ADDR_W), .WORDS(DC_WORDS), .LINES(DC_LINES)) u_dc_index (
        .addr(addr_q),
        .idx(dc_idx),
        .line_addr(dc_laddr)
    );

    clm_line_index #(.ADDR_W(ADDR_W), .WORDS(IC_WORDS), .LINES(IC_LINES)) u_ic_index (
        .addr(addr_q),
        .idx(ic_idx),
        .line_addr()
    );

    // ----------------------------------------------------------------
    // Cache storage
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] dc_tag_q [DC_LINES];
    logic [DC_WORDS-1:0] dc_wv_q [DC_LINES];
    logic [31:0] dc_data_q [DC_LINES][DC_WORDS];
    logic [DC_LINES-1:0] dc_lv_q;
    logic [DC_LINES-1:0] dc_dirty_q;
    logic [IC_LINES-1:0] ic_lv_q;
    logic dc_inval;
    logic ic_inval;
    logic fill_go;

    assign fill_ready = state_q == clm_pkg::S_IDLE;
    assign fill_go = fill_valid && fill_ready && ce;
    assign dc_line_valid = dc_lv_q;
    assign ic_line_valid = ic_lv_q;

    // Fill data, tag and word valid bits
    always_ff @(posedge clk_sys)
    begin
        if (fill_go)
        begin
            dc_tag_q[fill_line] <= fill_tag;
            dc_data_q[fill_line][fill_word] <= fill_data;
            dc_wv_q[fill_line] <= (dc_lv_q[fill_line] ? dc_wv_q[fill_line] : '0)
                | (DC_WORDS'(1) << fill_word);
        end
    end

    // Data line valid and dirty; reset clears them, other updates only while the enable flag is high
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dc_lv_q <= '0;
            dc_dirty_q <= '0;
        end
        else if (ce)
        begin
            if (fill_go)
            begin
                dc_lv_q[fill_line] <= 1'b1;
                dc_dirty_q[fill_line] <= fill_dirty | (dc_lv_q[fill_line] & dc_dirty_q[fill_line]);
            end
            else if (dc_inval)
            begin
                dc_lv_q[dc_idx] <= 1'b0;
                dc_dirty_q[dc_idx] <= 1'b0;
            end
        end
    end

    // Instruction line valid
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ic_lv_q <= '0;
        end
        else if (ce)
        begin
            if (ic_fill_valid && fill_ready)
            begin
                ic_lv_q[ic_fill_line] <= 1'b1;
            end
            else if (ic_inval)
            begin
                ic_lv_q[ic_idx] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic tag_hit;
    logic clear_now;
    logic wb_last;
    logic wb_step;
    logic need_wb;

    assign op_ready = state_q == clm_pkg::S_IDLE;
    assign tag_hit = dc_lv_q[dc_idx] && dc_tag_q[dc_idx] == dc_laddr;
    // Invalidate unconditionally unless write-back tag match
    assign clear_now = !q_match || DATA_CACHE_POLICY_OPTION == 0 || tag_hit;
    assign need_wb = DATA_CACHE_POLICY_OPTION == 1 && q_flush && dc_lv_q[dc_idx] && dc_dirty_q[dc_idx];
    assign wb_last = wcnt_q == WW'(DC_WORDS - 1);
    assign wb_step = state_q == clm_pkg::S_WB && (mem_wr_ready || !dc_wv_q[dc_idx][wcnt_q]);

    // Completion, exception and invalidate strobes
    always_comb
    begin
        done = 1'b0;
        dc_inval = 1'b0;
        ic_inval = 1'b0;
        case (state_q)
            clm_pkg::S_LOOK:
            begin
                if (priv_q)
                begin
                    done = 1'b1;
                end
                else if (op_q.is_ic)
                begin
                    done = 1'b1;
                    ic_inval = 1'b1;
                end
                else if (!need_wb && !q_ext && !(AREA_OPTION == 1 && !q_match && !q_flush))
                begin
                    done = 1'b1;
                    dc_inval = clear_now;
                end
            end
            clm_pkg::S_EXTRA:
            begin
                done = 1'b1;
                dc_inval = clear_now;
            end
            clm_pkg::S_WB:
            begin
                done = wb_step && wb_last;
                dc_inval = wb_step && wb_last;
            end
            clm_pkg::S_EXT:
            begin
                done = ext_req_ready;
                dc_inval = ext_req_ready;
            end
            default:
            begin
                done = 1'b0;
            end
        endcase
        if (!ce)
        begin
            done = 1'b0;
            dc_inval = 1'b0;
            ic_inval = 1'b0;
        end
    end

    assign exc_valid = done && priv_q;

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= clm_pkg::S_IDLE;
        end
        else if (ce)
        begin
            case (state_q)
                clm_pkg::S_IDLE:
                begin
                    if (accept)
                    begin
                        state_q <= clm_pkg::S_LOOK;
                    end
                end
                clm_pkg::S_LOOK:
                begin
                    if (done)
                    begin
                        state_q <= clm_pkg::S_IDLE;
                    end
                    else if (need_wb)
                    begin
                        state_q <= clm_pkg::S_WB;
                    end
                    else if (q_ext)
                    begin
                        state_q <= clm_pkg::S_EXT;
                    end
                    else
                    begin
                        state_q <= clm_pkg::S_EXTRA;
                    end
                end
                clm_pkg::S_EXTRA, clm_pkg::S_WB, clm_pkg::S_EXT:
                begin
                    if (done)
                    begin
                        state_q <= clm_pkg::S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= clm_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Captured operation and privilege verdict
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            op_q <= '0;
            addr_q <= '0;
            priv_q <= 1'b0;
        end
        else if (accept)
        begin
            op_q <= op;
            addr_q <= addr_d;
            priv_q <= TRANSLATION_UNIT_OPTION >= 1 && user_privilege_flag;
        end
    end

    // Cause field holds the last exception
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            exception_cause_field <= `CLM_CAUSE_RESET;
        end
        else if (exc_valid)
        begin
            exception_cause_field <= `CLM_CAUSE_PRIV;
        end
    end

    // Write-back word counter
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wcnt_q <= '0;
        end
        else if (ce)
        begin
            if (state_q != clm_pkg::S_WB)
            begin
                wcnt_q <= '0;
            end
            else if (wb_step)
            begin
                wcnt_q <= wcnt_q + WW'(1);
            end
        end
    end

    // Write-back word at line address plus four per word, valid words only
    assign mem_wr_valid = state_q == clm_pkg::S_WB && dc_wv_q[dc_idx][wcnt_q];
    assign mem_wr_addr = dc_laddr + ADDR_W'({wcnt_q, 2'b00});
    assign mem_wr_data = dc_data_q[dc_idx][wcnt_q];

    // External request at summed address
    assign ext_req_valid = state_q == clm_pkg::S_EXT;
    assign ext_req_flush = q_flush;
    assign ext_req_addr = addr_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_PRIV_CAUSE: assert property (@(posedge clk_sys) disable iff (rst)
        exc_valid |=> exception_cause_field == `CLM_CAUSE_PRIV)
        else $error("privilege cause not 00111");
    AST_PRIV_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == clm_pkg::S_LOOK && priv_q && ce) |-> (exc_valid && !dc_inval && !ic_inval && !ext_req_valid))
        else $error("privilege fault touched cache");
    AST_PRIV_USER: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && op.is_ic && user_privilege_flag && TRANSLATION_UNIT_OPTION >= 1 && ce)
        ##1 ce |-> exc_valid)
        else $error("user instruction write not refused");
    AST_CLEAR_LAT: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && !op.is_ic && !fbit(op.func, `CLM_BIT_FLUSH) && fbit(op.func, `CLM_BIT_MATCH)
        && !fbit(op.func, `CLM_BIT_EXT)) ##1 ce |-> done)
        else $error("clear not done in two cycles");
    AST_IC_LAT: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && op.is_ic) ##1 ce |-> done)
        else $error("instruction write not done in two cycles");
    AST_IC_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (done && op_q.is_ic && !priv_q) |=> !ic_lv_q[$past(ic_idx)])
        else $error("instruction line still valid");
    AST_WB_ONLY_FLUSH: assert property (@(posedge clk_sys) disable iff (rst)
        mem_wr_valid |-> (DATA_CACHE_POLICY_OPTION == 1 && q_flush && !priv_q))
        else $error("write-back outside flush");
    AST_WB_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
        (mem_wr_valid && mem_wr_ready && ce && !wb_last) |=> mem_wr_addr[ADDR_W-1:2] != $past(mem_wr_addr[ADDR_W-1:2]))
        else $error("write-back address did not advance");
    AST_EXT_ONLY_COHERENT: assert property (@(posedge clk_sys) disable iff (rst)
        ext_req_valid |-> (INTERCONNECT_OPTION == `CLM_ICONN_COHERENT && DATA_CACHE_POLICY_OPTION == 0))
        else $error("external request in wrong configuration");
    AST_MATCH_MISS: assert property (@(posedge clk_sys) disable iff (rst)
        (dc_inval && q_match && DATA_CACHE_POLICY_OPTION == 1) |-> tag_hit)
        else $error("matched clear hit wrong line");
endmodule
`default_nettype wire

// >>> clm_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Interconnect and external cache responder
// ----------------------------------------
module clm_mem_model (
    // Clock, reset, pace
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    // Write-back beats
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [31:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data,
    // External cache requests
    input wire logic ext_req_valid,
    output logic ext_req_ready,
    // Accepted counts
    output logic [7:0] wr_count,
    output logic [7:0] ext_count
);
    logic [31:0] log_addr [0:15];
    logic [31:0] log_data [0:15];
    logic tick_q;
    // Pace toggles so a slow interconnect stalls every other cycle
    always_ff @(posedge clk_sys)
    begin
        tick_q <= rst ? 1'b0 : ~tick_q;
    end
    // Ready outputs
    assign mem_wr_ready = slow ? tick_q : 1'b1;
    assign ext_req_ready = 1'b1;
    // Log of accepted beats and requests
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_count <= 8'h00;
            ext_count <= 8'h00;
        end
        else
        begin
            if (mem_wr_valid && mem_wr_ready)
            begin
                log_addr[wr_count[3:0]] <= mem_wr_addr;
                log_data[wr_count[3:0]] <= mem_wr_data;
                wr_count <= wr_count + 8'h01;
            end
            if (ext_req_valid && ext_req_ready)
                ext_count <= ext_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys, rst, ce, op_valid, user_privilege_flag, translation_active;
    logic fill_valid, fill_dirty, ic_fill_valid, slow, exc;
    logic [5:0] fill_line, ic_fill_line;
    logic [1:0] fill_word;
    logic [31:0] fill_tag, fill_data, mem_wr_addr, mem_wr_data, ext_req_addr;
    logic op_ready, done, exc_valid, fill_ready, mem_wr_valid, mem_wr_ready;
    logic ext_req_valid, ext_req_ready, ext_req_flush;
    logic [4:0] exception_cause_field;
    logic [63:0] dc_line_valid, ic_line_valid;
    logic [7:0] wr_count, ext_count;
    clm_pkg::clm_op_t op;
    logic wt_ext_valid, wt_ext_flush, wt_ext_f;
    logic [31:0] wt_ext_addr, wt_ext_a;
    logic [63:0] wt_dc_valid;
    logic [7:0] wt_ext_n;
    int fail_count, cmp_count, lat;
    // ----------------------------------------
    // Clock and instances
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    clm_maint #(.TRANSLATION_UNIT_OPTION(1), .INTERCONNECT_OPTION(3)) clm_maint_i (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .op_valid(op_valid), .op_ready(op_ready), .op(op),
        .user_privilege_flag(user_privilege_flag), .translation_active(translation_active),
        .done(done), .exc_valid(exc_valid), .exception_cause_field(exception_cause_field),
        .fill_valid(fill_valid), .fill_ready(fill_ready), .fill_line(fill_line), .fill_word(fill_word),
        .fill_tag(fill_tag), .fill_data(fill_data), .fill_dirty(fill_dirty),
        .ic_fill_valid(ic_fill_valid), .ic_fill_line(ic_fill_line),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .ext_req_valid(ext_req_valid), .ext_req_ready(ext_req_ready),
        .ext_req_flush(ext_req_flush), .ext_req_addr(ext_req_addr),
        .dc_line_valid(dc_line_valid), .ic_line_valid(ic_line_valid));
    clm_mem_model clm_mem_model_i (
        .clk_sys(clk_sys), .rst(rst), .slow(slow), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .ext_req_valid(ext_req_valid), .ext_req_ready(ext_req_ready),
        .wr_count(wr_count), .ext_count(ext_count));
    // Write-through instance on the coherent interconnect, sharing the stimulus
    clm_maint #(.DATA_CACHE_POLICY_OPTION(0), .INTERCONNECT_OPTION(3)) clm_maint_wt_i (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .op_valid(op_valid), .op_ready(), .op(op),
        .user_privilege_flag(user_privilege_flag), .translation_active(translation_active),
        .done(), .exc_valid(), .exception_cause_field(),
        .fill_valid(fill_valid), .fill_ready(), .fill_line(fill_line), .fill_word(fill_word),
        .fill_tag(fill_tag), .fill_data(fill_data), .fill_dirty(fill_dirty),
        .ic_fill_valid(ic_fill_valid), .ic_fill_line(ic_fill_line),
        .mem_wr_valid(), .mem_wr_ready(1'b1), .mem_wr_addr(), .mem_wr_data(),
        .ext_req_valid(wt_ext_valid), .ext_req_ready(1'b1), .ext_req_flush(wt_ext_flush),
        .ext_req_addr(wt_ext_addr), .dc_line_valid(wt_dc_valid), .ic_line_valid());
    // Log of external requests, always accepted at once
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wt_ext_n <= 8'h00;
        else if (wt_ext_valid)
        begin
            wt_ext_n <= wt_ext_n + 8'h01;
            wt_ext_a <= wt_ext_addr;
            wt_ext_f <= wt_ext_flush;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // One word fill, idle so taken at the first edge
    task automatic fill(input logic [5:0] ln, input logic [1:0] w, input logic [31:0] tg, input logic dy);
        @(posedge clk_sys);
        fill_valid <= 1'b1;
        fill_line <= ln;
        fill_word <= w;
        fill_tag <= tg;
        fill_data <= tg + {30'h0, w};
        fill_dirty <= dy;
        @(posedge clk_sys);
        chk(fill_ready, 1);
        fill_valid <= 1'b0;
    endtask
    task automatic fill4(input logic [5:0] ln, input logic [31:0] tg, input logic dy);
        for (int w = 0; w < 4; w++)
            fill(ln, w[1:0], tg, dy);
    endtask
    // Issue one operation, count edges to done, then one edge to settle state
    task automatic issue(input logic ic, input logic [10:0] fn, input logic [31:0] a, b, input logic um);
        int k;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op <= '{is_ic: ic, func: fn, ra: a, rb: b, ra_phys: a};
        user_privilege_flag <= um;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (op_ready !== 1'b1 && k < 20);
        op_valid <= 1'b0;
        lat = 0;
        do
        begin
            @(posedge clk_sys);
            lat++;
        end
        while (done !== 1'b1 && lat < 50);
        exc = exc_valid;
        @(posedge clk_sys);
        if (k >= 20 || lat >= 50)
        begin
            $display("BAD t=%0t wait k=%h lat=%h", $time, k, lat);
            fail_count++;
            summarize();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(op_ready, 1);
        chk(exception_cause_field, 0);
        chk(dc_line_valid[31:0] | dc_line_valid[63:32], 0);
        chk(ic_line_valid[31:0] | ic_line_valid[63:32], 0);
    endtask
    // Dirty flush writes four words at the aligned line address
    task automatic t_flush(input logic sl);
        logic [7:0] n0;
        slow <= sl;
        fill4(6'h23, 32'h0000_1230, 1'b1);
        n0 = wr_count;
        issue(1'b0, 11'h010, 32'h0000_1200, 32'h0000_0034, 1'b0);
        if (!sl)
            chk(lat, 5);
        chk(wr_count - n0, 4);
        for (int i = 0; i < 4; i++)
        begin
            chk(clm_mem_model_i.log_addr[4'(n0 + i)], 32'h0000_1230 + 4 * i);
            chk(clm_mem_model_i.log_data[4'(n0 + i)], 32'h0000_1230 + i);
        end
        chk(dc_line_valid[35], 0);
        slow <= 1'b0;
    endtask
    // Plain invalidate drops a dirty line without write-back
    task automatic t_plain();
        logic [7:0] n0;
        fill4(6'h04, 32'h0000_2040, 1'b1);
        n0 = wr_count;
        issue(1'b0, 11'h000, 32'h0000_2000, 32'h0000_0040, 1'b0);
        chk(lat, 1);
        chk(wr_count, n0);
        chk(dc_line_valid[4], 0);
    endtask
    // Matched clear, flush never combined with match here
    task automatic t_match();
        fill4(6'h08, 32'h0000_3080, 1'b1);
        issue(1'b0, 11'h002, 32'h0000_7000, 32'h0000_0084, 1'b0);
        chk(dc_line_valid[8], 1);
        issue(1'b0, 11'h082, 32'h0000_3000, 32'h0000_0084, 1'b0);
        chk(lat, 1);
        chk(dc_line_valid[8], 0);
    endtask
    // External bit has no effect in write-back mode
    task automatic t_ext();
        logic [7:0] e0;
        fill4(6'h09, 32'h0000_3090, 1'b0);
        e0 = ext_count;
        issue(1'b0, 11'h402, 32'h0000_3000, 32'h0000_0090, 1'b0);
        chk(ext_count, e0);
        chk(dc_line_valid[9], 0);
    endtask
    // User mode faults leave every line alone
    task automatic t_priv();
        logic [7:0] n0;
        fill4(6'h0A, 32'h0000_30A0, 1'b1);
        n0 = wr_count;
        issue(1'b0, 11'h010, 32'h0000_30A0, 32'h0, 1'b1);
        chk(exc, 1);
        chk(exception_cause_field, 5'h07);
        chk(dc_line_valid[10], 1);
        chk(wr_count, n0);
        @(posedge clk_sys);
        ic_fill_valid <= 1'b1;
        ic_fill_line <= 6'h15;
        @(posedge clk_sys);
        ic_fill_valid <= 1'b0;
        issue(1'b1, 11'h000, 32'h0000_4150, 32'h0, 1'b1);
        chk(exc, 1);
        chk(ic_line_valid[21], 1);
    endtask
    // Instruction line cleared from the first register only
    task automatic t_ic();
        @(posedge clk_sys);
        ic_fill_valid <= 1'b1;
        ic_fill_line <= 6'h12;
        @(posedge clk_sys);
        ic_fill_valid <= 1'b0;
        issue(1'b1, 11'h000, 32'h0000_4120, 32'hFFFF_FFF0, 1'b0);
        chk(exc, 0);
        chk(lat, 1);
        chk(ic_line_valid[18], 0);
    endtask
    // Write-through: first register alone, external requests at the sum
    task automatic t_wt();
        logic [7:0] e0;
        fill4(6'h0C, 32'h0000_50C0, 1'b0);
        issue(1'b0, 11'h000, 32'h0000_50C0, 32'h0000_0F00, 1'b0);
        chk(wt_dc_valid[12], 0);
        e0 = wt_ext_n;
        fill4(6'h0D, 32'h0000_50D0, 1'b0);
        issue(1'b0, 11'h402, 32'h0000_5000, 32'h0000_00D0, 1'b0);
        @(posedge clk_sys);
        chk(wt_ext_n - e0, 1);
        chk(wt_ext_a, 32'h0000_50D0);
        chk(wt_ext_f, 0);
        chk(wt_dc_valid[13], 0);
        issue(1'b0, 11'h410, 32'h0000_5000, 32'h0000_00E0, 1'b0);
        @(posedge clk_sys);
        chk(wt_ext_n - e0, 2);
        chk(wt_ext_a, 32'h0000_50E0);
        chk(wt_ext_f, 1);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        ce = 1'b1;
        op_valid = 1'b0;
        op = '0;
        user_privilege_flag = 1'b0;
        translation_active = 1'b0;
        fill_valid = 1'b0;
        fill_line = 6'h00;
        fill_word = 2'h0;
        fill_tag = 32'h0;
        fill_data = 32'h0;
        fill_dirty = 1'b0;
        ic_fill_valid = 1'b0;
        ic_fill_line = 6'h00;
        slow = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_flush(1'b0);
        t_flush(1'b1);
        t_plain();
        t_match();
        t_ext();
        t_priv();
        t_ic();
        t_wt();
        summarize();
    end
endmodule
`default_nettype wire
